// ==== rtl/adc_conversion_sequencer.v ====
// conversion sequencer with avalon-mm register port and successive approximation control
// assumes the analog core compares its held input against sar_code and reports cmp_above
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"
module adc_conversion_sequencer (
  // clock and reset
  input wire core_clk,
  input wire resetn,
  // avalon-mm slave
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  // analog core control
  output reg conv_power_enable,
  output reg sample_phase,
  output wire conv_clk_tick,
  output reg [11:0] sar_code,
  input wire cmp_above,
  // analog routing
  output wire analog_ext_enable,
  output wire [3:0] analog_ext_channel,
  output wire [2:0] analog_int_source,
  output wire [1:0] analog_int_scale,
  output wire [2:0] analog_ref_pick,
  output reg analog_amp_enable,
  output reg analog_amp_input,
  output reg [1:0] ref_amp_gain_sel,
  // status
  output reg conv_busy_flag,
  output reg conv_irq
);
  localparam [2:0] st_idle = 3'b001;
  localparam [2:0] st_sample = 3'b010;
  localparam [2:0] st_convert = 3'b100;

  // recommended period window in core clocks, cut to the width of the divide count
  localparam integer win_lo_full = `CONV_CLK_MIN_CYC;
  localparam integer win_hi_full = `CONV_CLK_MAX_CYC;
  localparam [8:0] win_lo = win_lo_full[8:0];
  localparam [8:0] win_hi = win_hi_full[8:0];

  // register contents
  reg start_bit;
  reg result_format_sel;
  reg [3:0] external_channel_sel;
  reg [3:0] input_source_sel;
  reg [2:0] conv_clock_divide_sel;
  reg [1:0] reference_source_sel;
  reg conv_irq_flag;
  reg conv_irq_enable;
  reg global_irq_enable;
  reg [11:0] result;

  // sequencer state
  reg [2:0] state;
  reg [3:0] phase_cnt;
  reg conv_done;

  // bus state
  reg ack;
  wire req;
  wire wr_lane;
  wire wr_ctrl0;
  wire wr_ctrl1;
  wire wr_ctrl2;
  wire wr_irq;
  wire start_go;
  wire range_ok;
  wire [3:0] bit_idx;
  reg [11:0] next_code;
  reg [31:0] rd_mux;

  // one bit of the approximation register
  function [11:0] bit_mask;
    input [3:0] idx;
    begin
      bit_mask = 12'h001 << idx;
    end
  endfunction

  // register select for the write strobes
  function hit;
    input [4:0] addr;
    input [4:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // formats the 12-bit result into the high or low result byte
  function [7:0] fmt_byte;
    input high;
    input fmt;
    input [11:0] raw;
    begin
      if (fmt) begin
        fmt_byte = high ? {4'h0, raw[11:8]} : raw[7:0];
      end else begin
        fmt_byte = high ? raw[11:4] : {raw[3:0], 4'h0};
      end
    end
  endfunction

  // true when a divide setting lands inside the recommended period window
  function in_window;
    input [2:0] sel;
    reg [8:0] cycles;
    begin
      cycles = 9'h001 << sel;
      in_window = (cycles >= win_lo) && (cycles <= win_hi);
    end
  endfunction

  // one wait cycle per access, answer on the next edge
  assign req = read | write;
  assign waitrequest = req & ~ack;
  assign wr_lane = write & ack & byteenable[0];
  assign wr_ctrl0 = wr_lane & hit(address, `OFS_CTRL0);
  assign wr_ctrl1 = wr_lane & hit(address, `OFS_CTRL1);
  assign wr_ctrl2 = wr_lane & hit(address, `OFS_CTRL2);
  assign wr_irq = wr_lane & hit(address, `OFS_IRQ);

  // start fires on the write that takes the start bit from high to low
  // power gates with its old value, so one write cannot both power up and start
  assign start_go = wr_ctrl0 & start_bit & ~writedata[`C0_START]; // R1

  // advisory: only software can pick a sane divide for the real core clock
  assign range_ok = in_window(conv_clock_divide_sel); // R7

  conv_clock_divider u_div (
    .core_clk(core_clk),
    .resetn(resetn),
    .conv_clock_divide_sel(conv_clock_divide_sel),
    .restart(start_go),
    .conv_tick(conv_clk_tick)
  );

  analog_select u_sel (
    .input_source_sel(input_source_sel),
    .external_channel_sel(external_channel_sel),
    .reference_source_sel(reference_source_sel),
    .ext_enable(analog_ext_enable),
    .ext_channel(analog_ext_channel),
    .int_source(analog_int_source),
    .int_scale(analog_int_scale),
    .ref_pick(analog_ref_pick)
  );

  // read mux
  always @* begin
    rd_mux = 32'h00000000;
    case (address)
      `OFS_CTRL0: begin
        rd_mux[`C0_START] = start_bit;
        rd_mux[`C0_BUSY] = conv_busy_flag; // R5
        rd_mux[`C0_PWR] = conv_power_enable;
        rd_mux[`C0_FMT] = result_format_sel;
        rd_mux[3:0] = external_channel_sel;
      end
      `OFS_CTRL1: begin
        rd_mux[`C1_SRC_HI:`C1_SRC_LO] = input_source_sel;
        rd_mux[`C1_RANGE_OK] = range_ok;
        rd_mux[2:0] = conv_clock_divide_sel;
      end
      `OFS_CTRL2: begin
        rd_mux[`C2_AMP_EN] = analog_amp_enable;
        rd_mux[`C2_AMP_IN] = analog_amp_input;
        rd_mux[3:2] = reference_source_sel;
        rd_mux[1:0] = ref_amp_gain_sel;
      end
      `OFS_RES_HI: begin
        rd_mux[7:0] = fmt_byte(1'b1, result_format_sel, result); // R19
      end
      `OFS_RES_LO: begin
        rd_mux[7:0] = fmt_byte(1'b0, result_format_sel, result); // R19
      end
      `OFS_IRQ: begin
        rd_mux[`IRQ_FLAG] = conv_irq_flag;
        rd_mux[`IRQ_IE] = conv_irq_enable;
        rd_mux[`IRQ_GIE] = global_irq_enable;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // bus handshake and read data
  // readdata loads in the wait cycle so it stands at the answering edge
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      ack <= req & ~ack;
      if (read && !ack) begin
        readdata <= rd_mux;
      end
    end
  end

  // software-written control fields
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      start_bit <= 1'b0;
      conv_power_enable <= 1'b0;
      result_format_sel <= 1'b0;
      external_channel_sel <= 4'h0;
      input_source_sel <= 4'h0;
      conv_clock_divide_sel <= 3'h0;
      analog_amp_enable <= 1'b0;
      analog_amp_input <= 1'b0;
      reference_source_sel <= 2'h0;
      ref_amp_gain_sel <= 2'h0;
      conv_irq_enable <= 1'b0;
      global_irq_enable <= 1'b0;
    end else begin
      if (wr_ctrl0) begin
        start_bit <= writedata[`C0_START];
        conv_power_enable <= writedata[`C0_PWR]; // R8
        result_format_sel <= writedata[`C0_FMT];
        external_channel_sel <= writedata[3:0];
      end
      if (wr_ctrl1) begin
        input_source_sel <= writedata[`C1_SRC_HI:`C1_SRC_LO];
        conv_clock_divide_sel <= writedata[2:0];
      end
      if (wr_ctrl2) begin
        analog_amp_enable <= writedata[`C2_AMP_EN];
        analog_amp_input <= writedata[`C2_AMP_IN];
        reference_source_sel <= writedata[3:2];
        // 00 gain 1, 01 1.667, 10 2.5, 11 3.333
        ref_amp_gain_sel <= writedata[1:0]; // R22
      end
      if (wr_irq) begin
        conv_irq_enable <= writedata[`IRQ_IE];
        global_irq_enable <= writedata[`IRQ_GIE];
      end
    end
  end

  // bit under trial during the conversion phase, msb first
  assign bit_idx = 4'hb - phase_cnt;

  // approximation step: keep or drop the trial bit, then try the next one
  always @* begin
    next_code = sar_code;
    if (!cmp_above) begin
      next_code = next_code & ~bit_mask(bit_idx);
    end
    if (bit_idx != 4'h0) begin
      next_code = next_code | bit_mask(bit_idx - 4'h1);
    end
  end

  // sequencer runs on its own, the bus never stalls for it
  always @(posedge core_clk or negedge resetn) begin // R13
    if (!resetn) begin
      state <= st_idle;
      phase_cnt <= 4'h0;
      sar_code <= `RST_RESULT;
      result <= `RST_RESULT;
      conv_busy_flag <= 1'b0;
      sample_phase <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (!conv_power_enable) begin
        // power off abandons any conversion without completing it
        state <= st_idle; // R8
        phase_cnt <= 4'h0;
        sar_code <= `RST_RESULT;
        conv_busy_flag <= 1'b0;
        sample_phase <= 1'b0;
      end else if (start_go) begin
        // also taken mid-conversion: sampling begins again
        state <= st_sample; // R24
        phase_cnt <= 4'h0;
        sar_code <= `RST_RESULT;
        conv_busy_flag <= 1'b1; // R2
        sample_phase <= 1'b1;
      end else begin
        case (state)
          st_idle: begin
            sample_phase <= 1'b0;
          end
          st_sample: begin
            if (conv_clk_tick) begin
              if (phase_cnt == `SAMPLE_CLKS - 4'h1) begin
                state <= st_convert; // R11
                phase_cnt <= 4'h0;
                sample_phase <= 1'b0;
                sar_code <= `SAR_MSB;
              end else begin
                phase_cnt <= phase_cnt + 4'h1;
              end
            end
          end
          st_convert: begin
            if (conv_clk_tick) begin
              sar_code <= next_code;
              if (phase_cnt == `CONVERT_CLKS - 4'h1) begin
                state <= st_idle; // R12
                phase_cnt <= 4'h0;
                result <= next_code; // R23
                conv_busy_flag <= 1'b0; // R3
                conv_done <= 1'b1;
              end else begin
                phase_cnt <= phase_cnt + 4'h1;
              end
            end
          end
          default: begin
            state <= st_idle;
            phase_cnt <= 4'h0;
            conv_busy_flag <= 1'b0;
            sample_phase <= 1'b0;
          end
        endcase
      end
    end
  end

  // completion flag: write one to clear, a new completion wins over the clear
  // the request is registered so it never glitches on a decode
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      conv_irq_flag <= 1'b0;
      conv_irq <= 1'b0;
    end else begin
      if (conv_done) begin
        conv_irq_flag <= 1'b1; // R4
      end else if (wr_irq && writedata[`IRQ_FLAG]) begin
        conv_irq_flag <= 1'b0;
      end
      conv_irq <= conv_irq_flag & conv_irq_enable & global_irq_enable; // R4
    end
  end
endmodule // adc_conversion_sequencer
`default_nettype wire

// ==== rtl/adc_seq_consts.vh ====
// constants for the conversion sequencer: register offsets, fields, reset values, timing
// assumes a 32-bit avalon-mm register port, core clock 25 mhz
//
// Function
// (R1) a conversion starts when software writes the start bit high, then low
// (R2) busy flag sets once a conversion starts and holds during it
// (R3) busy flag clears when the conversion completes
// (R4) completion sets the interrupt flag; enables gate it onto the request
// (R5) without interrupts, software polls busy until it reads low
// (R6) divide select 000 passes core clock, 001..111 divide by 2..128
// (R7) software keeps conversion clock period between 0.5 and 10 us
// (R8) converter powered only while the power enable bit is high
// (R9) software waits a settling delay after power enable before starting
// (R10) software clears power enable when the converter is unused
// (R11) sampling phase lasts exactly 4 conversion clock periods
// (R12) conversion phase lasts 12 periods, 16 periods busy in total
// (R13) conversion runs in hardware without stalling the processor
// (R14) sources 0000, 0100, 11xx convert the selected external channel
// (R15) sources 0x01, 0x10, 0x11 convert internal signals, external input cut
// (R16) software sets result format before converting
// (R17) software programs reference select, and amplifier input and gain
// (R18) interrupt use needs global and converter enables set before start
// (R19) result registers valid once busy clears; read only then
// (R20) internal map: supply /1 /2 /4, amp ref /1 /2 /4, 10xx ground
// (R21) reference: 00 supply, 01 external pin, 1x amplified reference
// (R22) gain codes 00..11 give 1, 1.667, 2.5, 3.333
// (R23) result is 12 bits, full scale fff at the reference
// (R24) a start during a conversion restarts sampling, busy stays set
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// byte offsets
`define OFS_CTRL0 5'h00
`define OFS_CTRL1 5'h04
`define OFS_CTRL2 5'h08
`define OFS_RES_HI 5'h0c
`define OFS_RES_LO 5'h10
`define OFS_IRQ 5'h14

// control 0 fields
`define C0_START 7
`define C0_BUSY 6
`define C0_PWR 5
`define C0_FMT 4
// control 1 fields
`define C1_SRC_HI 7
`define C1_SRC_LO 4
`define C1_RANGE_OK 3
// control 2 fields
`define C2_AMP_EN 7
`define C2_AMP_IN 4
// irq register fields
`define IRQ_FLAG 0
`define IRQ_IE 1
`define IRQ_GIE 2

// reset values
`define RST_BYTE 8'h00
`define RST_RESULT 12'h000

// phase lengths in conversion clocks
`define SAMPLE_CLKS 4'h4
`define CONVERT_CLKS 4'hc
`define SAR_MSB 12'h800

// timing
`define CORE_CLK_NS 40
`define CONV_CLK_MIN_NS 500
`define CONV_CLK_MAX_NS 10000
`define CONV_CLK_MIN_CYC ((`CONV_CLK_MIN_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define CONV_CLK_MAX_CYC (`CONV_CLK_MAX_NS / `CORE_CLK_NS)

`endif

// ==== rtl/analog_select.v ====
// analog input and reference routing decode
// assumes the analog core applies these selects directly
`timescale 1ns/1ps
`default_nettype none
module analog_select (
  // selections
  input wire [3:0] input_source_sel,
  input wire [3:0] external_channel_sel,
  input wire [1:0] reference_source_sel,
  // input routing
  output reg ext_enable,
  output wire [3:0] ext_channel,
  output reg [2:0] int_source,
  output wire [1:0] int_scale,
  // reference routing
  output wire [2:0] ref_pick
);
  // int_source one-hot: bit0 supply, bit1 amplified ref, bit2 ground
  always @* begin
    ext_enable = 1'b0;
    int_source = 3'h0;
    casez (input_source_sel)
      4'b0000, 4'b0100, 4'b11??: ext_enable = 1'b1; // R14
      4'b10??: int_source = 3'h4; // R20
      4'b00??: int_source = 3'h1; // R20
      default: int_source = 3'h2; // R20
    endcase
  end

  // channel forced off so it never shorts onto an internal signal
  assign ext_channel = ext_enable ? external_channel_sel : 4'h0; // R15
  // scale 00 /1, 01 /2, 10 /4
  assign int_scale = ext_enable ? 2'h0 : input_source_sel[1:0] - 2'h1; // R20
  // one-hot: bit0 supply, bit1 external pin, bit2 amplified reference
  assign ref_pick = reference_source_sel[1] ? 3'h4 :
                    (reference_source_sel[0] ? 3'h2 : 3'h1); // R21
endmodule // analog_select
`default_nettype wire

// ==== rtl/conv_clock_divider.v ====
// conversion clock tick generator
// assumes restart is a one-cycle pulse from the sequencer
`timescale 1ns/1ps
`default_nettype none
module conv_clock_divider (
  // clock and reset
  input wire core_clk,
  input wire resetn,
  // control
  input wire [2:0] conv_clock_divide_sel,
  input wire restart,
  // tick out
  output wire conv_tick
);
  reg [6:0] count;
  wire [6:0] terminal;

  // 000 ticks every cycle, n ticks every 2**n cycles
  assign terminal = (7'h01 << conv_clock_divide_sel) - 7'h01; // R6
  assign conv_tick = ~restart & (count == terminal);

  // restart aligns the first period to the start pulse
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count <= 7'h00;
    end else if (restart || count == terminal) begin
      count <= 7'h00;
    end else begin
      count <= count + 7'h01;
    end
  end
endmodule // conv_clock_divider
`default_nettype wire

// ==== tb/adc_seq_properties.sv ====
// port checker for the conversion sequencer, bound onto its top module
// assumes one clock, core_clk, and the asynchronous active-low resetn
`timescale 1ns/1ps
`default_nettype none
module adc_seq_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // bus
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // converter
  input wire logic conv_power_enable,
  input wire logic sample_phase,
  input wire logic conv_clk_tick,
  input wire logic [11:0] sar_code,
  input wire logic conv_busy_flag,
  input wire logic conv_irq,
  // routing
  input wire logic analog_ext_enable,
  input wire logic [3:0] analog_ext_channel,
  input wire logic [2:0] analog_int_source,
  input wire logic [1:0] analog_int_scale,
  input wire logic [2:0] analog_ref_pick
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [4:0] scnt;
  logic [4:0] bcnt;
  logic sprev;
  // tick counts per phase; a restart from the conversion phase clears the total so it measures the new run only, one during sampling does not
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      scnt <= 5'h00;
      bcnt <= 5'h00;
      sprev <= 1'b0;
    end else begin
      sprev <= sample_phase;
      scnt <= !sample_phase ? 5'h00 : scnt + {4'h0, conv_clk_tick};
      bcnt <= !conv_busy_flag ? 5'h00 :
        (sample_phase && !sprev) ? {4'h0, conv_clk_tick} : bcnt + {4'h0, conv_clk_tick};
    end
  end
  busy_on_a: assert property ($rose(sample_phase) |-> conv_busy_flag)
    else $error("busy low when sampling began");
  sample_len_a: assert property ($fell(sample_phase) && conv_busy_flag |-> scnt == 5'h04)
    else $error("sampling did not last four ticks");
  busy_len_a: assert property ($fell(conv_busy_flag) && conv_power_enable |-> bcnt == 5'h10)
    else $error("busy did not last sixteen ticks");
  sar_entry_a: assert property ($fell(sample_phase) && conv_busy_flag |-> sar_code == 12'h800)
    else $error("trial code wrong entering conversion");
  power_off_a: assert property (!conv_power_enable |=> !conv_busy_flag && !sample_phase)
    else $error("conversion runs without power");
  no_stall_a: assert property (conv_busy_flag && (read || write) && waitrequest |=> !waitrequest)
    else $error("bus stalled during conversion");
  ext_cut_a: assert property (!analog_ext_enable |->
    analog_ext_channel == 4'h0 && $onehot(analog_int_source))
    else $error("external input not cut for internal source");
  ext_route_a: assert property (analog_ext_enable |->
    analog_int_source == 3'h0 && analog_int_scale == 2'h0)
    else $error("internal source active with external channel");
  ref_pick_a: assert property ($onehot(analog_ref_pick))
    else $error("reference pick not one-hot");
  cover property ($fell(conv_busy_flag));
  cover property ($rose(conv_irq));
  cover property ($rose(sample_phase) && $past(conv_busy_flag));
endmodule // adc_seq_properties

bind adc_conversion_sequencer adc_seq_properties adc_seq_properties_i (
  .core_clk(core_clk), .resetn(resetn), .read(read), .write(write),
  .waitrequest(waitrequest), .conv_power_enable(conv_power_enable),
  .sample_phase(sample_phase), .conv_clk_tick(conv_clk_tick), .sar_code(sar_code),
  .conv_busy_flag(conv_busy_flag), .conv_irq(conv_irq), .analog_ext_enable(analog_ext_enable),
  .analog_ext_channel(analog_ext_channel), .analog_int_source(analog_int_source),
  .analog_int_scale(analog_int_scale), .analog_ref_pick(analog_ref_pick)
);
`default_nettype wire

// ==== tb/analog_core_model.sv ====
// behavioural analog core: tracks its input while sampling and holds it after, compares it with the trial code
// assumes level is steady while sample_phase is high
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
  // clock
  input wire logic core_clk,
  // from the sequencer
  input wire logic conv_power_enable,
  input wire logic sample_phase,
  input wire logic [11:0] sar_code,
  // analog input as a code
  input wire logic [11:0] level,
  // comparator
  output logic cmp_above
);
  logic [11:0] held = 12'h000;
  logic junk = 1'b0;
  // an unpowered comparator means nothing, so it toggles rather than hold a tidy value
  always @(posedge core_clk) begin
    junk <= ~junk;
    if (sample_phase) begin
      held <= level;
    end
  end
  assign cmp_above = conv_power_enable ? (held >= sar_code) : junk;
endmodule // analog_core_model
`default_nettype wire

// ==== tb/test_adc_conversion_sequencer.sv ====
// self-checking bench for the conversion sequencer with an analog core model
// assumes the two-edge avalon-mm access of the sequencer and a 25 mhz core clock
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_sequencer;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [11:0] level = 12'h000;
  wire [31:0] readdata;
  wire [11:0] sar_code;
  wire [3:0] analog_ext_channel;
  wire [2:0] analog_int_source, analog_ref_pick;
  wire [1:0] analog_int_scale, ref_amp_gain_sel;
  wire waitrequest, conv_power_enable, sample_phase, conv_clk_tick, cmp_above;
  wire analog_ext_enable, analog_amp_enable, analog_amp_input, conv_busy_flag, conv_irq;
  int fails = 0;
  int n_compared = 0;
  int n;
  logic e;
  logic [7:0] d;
  logic [39:0] row;
  // divide, format, irq enable, level, result high, result low
  logic [39:0] rows [8] = '{40'h0_0_1_abc_ab_c0, 40'h1_1_0_fff_0f_ff, 40'h2_0_0_000_00_00,
    40'h3_1_1_801_08_01, 40'h4_0_1_7fe_7f_e0, 40'h5_1_0_123_01_23, 40'h6_0_0_555_55_50,
    40'h7_1_1_aaa_0a_aa};
  always #20 core_clk = ~core_clk;
  adc_conversion_sequencer adc_conversion_sequencer_i (.core_clk(core_clk), .resetn(resetn),
    .address(address), .read(read), .write(write), .byteenable(4'hf), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .conv_power_enable(conv_power_enable),
    .sample_phase(sample_phase), .conv_clk_tick(conv_clk_tick), .sar_code(sar_code),
    .cmp_above(cmp_above), .analog_ext_enable(analog_ext_enable),
    .analog_ext_channel(analog_ext_channel), .analog_int_source(analog_int_source),
    .analog_int_scale(analog_int_scale), .analog_ref_pick(analog_ref_pick),
    .analog_amp_enable(analog_amp_enable), .analog_amp_input(analog_amp_input),
    .ref_amp_gain_sel(ref_amp_gain_sel), .conv_busy_flag(conv_busy_flag), .conv_irq(conv_irq));
  analog_core_model analog_core_model_i (.core_clk(core_clk),
    .conv_power_enable(conv_power_enable), .sample_phase(sample_phase), .sar_code(sar_code),
    .level(level), .cmp_above(cmp_above));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // one access; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] wd);
    @(posedge core_clk);
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= {24'h000000, wd};
    @(posedge core_clk);
    while (waitrequest !== 1'b0) @(posedge core_clk);
    d = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic pulse(input logic [7:0] c0);
    bus(1'b1, 5'h00, c0 | 8'h80);
    bus(1'b1, 5'h00, c0);
  endtask
  task automatic run(output int cyc);
    cyc = 0;
    @(negedge core_clk);
    while (conv_busy_flag === 1'b1 && cyc < 5000) begin
      cyc++;
      @(negedge core_clk);
    end
  endtask
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    bus(1'b1, 5'h00, 8'h20);
    // settling time after power-up before any start
    repeat (20) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      row = rows[i];
      level <= row[27:16];
      bus(1'b1, 5'h14, {5'h00, 1'b1, row[28], 1'b0});
      bus(1'b1, 5'h04, {5'h00, row[38:36]});
      bus(1'b0, 5'h04, 8'h00);
      chk(d[3], row[38:36] >= 3'h4, "period window");
      pulse({3'b001, row[32], 4'h3});
      run(n);
      chk(n, 32'h10 << row[38:36], "busy cycles");
      bus(1'b0, 5'h00, 8'h00);
      chk(d[6], 1'b0, "busy bit");
      @(negedge core_clk);
      chk(conv_irq, row[28], "irq line");
      bus(1'b0, 5'h14, 8'h00);
      chk(d[0], 1'b1, "irq flag");
      bus(1'b0, 5'h0c, 8'h00);
      chk(d, row[15:8], "result high");
      bus(1'b0, 5'h10, 8'h00);
      chk(d, row[7:0], "result low");
      bus(1'b1, 5'h14, 8'h01);
      bus(1'b0, 5'h14, 8'h00);
      chk(d[0], 1'b0, "irq flag clear");
    end
    bus(1'b1, 5'h04, 8'h02);
    pulse(8'h20);
    repeat (30) @(posedge core_clk);
    bus(1'b0, 5'h00, 8'h00);
    chk(d[6], 1'b1, "busy bit mid run");
    pulse(8'h20);
    run(n);
    chk(n, 64, "restart busy cycles");
    bus(1'b1, 5'h14, 8'h01);
    bus(1'b1, 5'h04, 8'h03);
    pulse(8'h20);
    repeat (40) @(posedge core_clk);
    bus(1'b1, 5'h00, 8'h00);
    repeat (2) @(negedge core_clk);
    chk(conv_busy_flag, 1'b0, "busy after power off");
    chk(conv_power_enable, 1'b0, "power enable");
    bus(1'b0, 5'h14, 8'h00);
    chk(d[0], 1'b0, "irq flag after abort");
    bus(1'b0, 5'h0c, 8'h00);
    chk(d, 8'haa, "result kept");
    pulse(8'h00);
    repeat (8) @(negedge core_clk);
    chk(conv_busy_flag, 1'b0, "busy without power");
    bus(1'b1, 5'h00, 8'h23);
    repeat (20) @(posedge core_clk);
    bus(1'b1, 5'h00, 8'ha3);
    repeat (8) @(negedge core_clk);
    chk(conv_busy_flag, 1'b0, "busy before start falls");
    bus(1'b1, 5'h00, 8'h23);
    run(n);
    chk(n, 128, "busy after falling start");
    for (int s = 0; s < 16; s++) begin
      bus(1'b1, 5'h04, {s[3:0], 4'h0});
      @(negedge core_clk);
      e = (s == 0) || (s == 4) || (s >= 12);
      chk(analog_ext_enable, e, "ext enable");
      chk(analog_ext_channel, e ? 3 : 0, "ext channel");
      chk(analog_int_source, e ? 0 : (s < 4 ? 1 : (s < 8 ? 2 : 4)), "int source");
      if (!e && s < 8) chk(analog_int_scale, (s - 1) & 3, "int scale");
    end
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, 5'h08, {4'h9, r[1:0], r[1:0]});
      @(negedge core_clk);
      chk(analog_ref_pick, r > 1 ? 4 : (r == 1 ? 2 : 1), "reference pick");
      chk(ref_amp_gain_sel, r, "gain select");
      chk(analog_amp_enable, 1'b1, "amp enable");
      chk(analog_amp_input, 1'b1, "amp input");
    end
    // reset in mid-run, then every register and one unmapped place read zero
    pulse(8'h23);
    @(negedge core_clk);
    chk(conv_busy_flag, 1'b1, "busy before reset");
    resetn <= 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    bus(1'b1, 5'h18, 8'hff);
    for (int a = 0; a < 28; a += 4) begin
      bus(1'b0, a[4:0], 8'h00);
      chk(d, 8'h00, "reset value");
    end
    conclude();
  end
  initial begin
    #2000000;
    fails++;
    conclude();
  end
endmodule // test_adc_conversion_sequencer
`default_nettype wire
